// ---- verilog/atc_compute.sv ----
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "atc_defines.svh"
module atc_compute
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire atc_pkg::atc_sample_s conv_in,
    output logic conv_start,
    output logic threshold_flag
);

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    function automatic logic hit_off(input logic [7:0] addr, input logic [7:0] off);
        hit_off = (addr == off);
    endfunction : hit_off

    wire logic sel_ctrl;
    wire logic sel_calc;
    wire logic sel_resh;
    wire logic sel_resl;
    wire logic sel_setpoint_value;
    wire logic sel_lth;
    wire logic sel_uth;
    wire logic sel_err;
    wire logic sel_stat;
    wire logic mapped;
    wire logic setup_phase;
    wire logic wr_access;

    assign sel_ctrl = hit_off(paddr, `ATC_OFF_CTRL);
    assign sel_calc = hit_off(paddr, `ATC_OFF_CALC);
    assign sel_resh = hit_off(paddr, `ATC_OFF_RESH);
    assign sel_resl = hit_off(paddr, `ATC_OFF_RESL);
    assign sel_setpoint_value = hit_off(paddr, `ATC_OFF_SETPOINT_VALUE);
    assign sel_lth = hit_off(paddr, `ATC_OFF_LTH);
    assign sel_uth = hit_off(paddr, `ATC_OFF_UTH);
    assign sel_err = hit_off(paddr, `ATC_OFF_ERR);
    assign sel_stat = hit_off(paddr, `ATC_OFF_STAT);
    assign mapped = sel_ctrl || sel_calc || sel_resh || sel_resl || sel_setpoint_value
        || sel_lth || sel_uth || sel_err || sel_stat;
    assign setup_phase = psel && !penable;
    assign wr_access = psel && penable && pwrite && mapped;

    // zero wait states; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // ----------------------------------------------------------------
    // register state
    // ----------------------------------------------------------------
    logic go;
    logic continuous_retrigger;
    logic double_sample_enable;
    logic previous_source_select;
    atc_pkg::atc_calc_s calc_cfg;
    logic [11:0] conversion_result;
    logic [11:0] prev_result;
    logic [15:0] prev_filtered;
    logic signed [`ATC_THR_W-1:0] setpoint_value;
    logic signed [`ATC_THR_W-1:0] lower_threshold;
    logic signed [`ATC_THR_W-1:0] upper_threshold;
    logic signed [`ATC_ERR_W-1:0] error_value;
    logic flag;

    // ----------------------------------------------------------------
    // error computation
    // ----------------------------------------------------------------
    wire logic signed [`ATC_ERR_W-1:0] res_ext;
    wire logic signed [`ATC_ERR_W-1:0] s1_ext;
    wire logic signed [`ATC_ERR_W-1:0] prev_res_ext;
    wire logic signed [`ATC_ERR_W-1:0] prev_flt_ext;
    wire logic signed [`ATC_ERR_W-1:0] flt_ext;
    wire logic signed [`ATC_ERR_W-1:0] setpoint_value_ext;
    wire logic signed [`ATC_ERR_W-1:0] prev_sel;
    wire logic signed [`ATC_ERR_W-1:0] res_minus_prev;
    wire logic signed [`ATC_ERR_W-1:0] res_term;
    logic signed [`ATC_ERR_W-1:0] next_error;

    assign res_ext = `ATC_ERR_W'(signed'({1'b0, conv_in.result}));
    assign s1_ext = `ATC_ERR_W'(signed'({1'b0, conv_in.first_sample}));
    assign prev_res_ext = `ATC_ERR_W'(signed'({1'b0, prev_result}));
    assign prev_flt_ext = `ATC_ERR_W'(signed'(prev_filtered));
    assign flt_ext = `ATC_ERR_W'(signed'(conv_in.filtered_value));
    assign setpoint_value_ext = `ATC_ERR_W'(setpoint_value);

    // previous value is the last result, or the last filtered value when selected
    assign prev_sel = previous_source_select ? prev_flt_ext : prev_res_ext;

    // double-sample pair with source select clear uses second minus first
    assign res_minus_prev = (double_sample_enable && !previous_source_select)
        ? `ATC_ERR_W'(res_ext - s1_ext)
        : `ATC_ERR_W'(res_ext - prev_sel);

    // in double-sample mode the measurement replaces the plain result
    assign res_term = double_sample_enable ? res_minus_prev : res_ext;

    always_comb
    begin
        unique case (calc_cfg.error_calc_mode)
            atc_pkg::ATC_CALC_RES_PREV: next_error = res_minus_prev;
            atc_pkg::ATC_CALC_RES_SETPOINT_VALUE: next_error = `ATC_ERR_W'(res_term - setpoint_value_ext);
            atc_pkg::ATC_CALC_RES_FILTERED_VALUE: next_error = `ATC_ERR_W'(res_term - flt_ext);
            atc_pkg::ATC_CALC_PREV_FILTERED_VALUE: next_error = `ATC_ERR_W'(prev_sel - flt_ext);
            atc_pkg::ATC_CALC_FILTERED_VALUE_SETPOINT_VALUE: next_error = `ATC_ERR_W'(flt_ext - setpoint_value_ext);
            // reserved codes produce a zero error
            default: next_error = `ATC_ERR_RST;
        endcase
    end

    // ----------------------------------------------------------------
    // threshold test on the freshly computed error
    // ----------------------------------------------------------------
    wire logic thresh_hit;
    wire logic event_hit;

    atc_thresh_cmp u_cmp
    (
        .error_value(next_error),
        .lower_threshold(lower_threshold),
        .upper_threshold(upper_threshold),
        .threshold_irq_mode(calc_cfg.threshold_irq_mode),
        .hit(thresh_hit)
    );

    assign event_hit = conv_in.done && thresh_hit;

    // ----------------------------------------------------------------
    // conversion start control
    // ----------------------------------------------------------------
    wire logic wr_ctrl;
    wire logic hw_stop;
    logic next_go;

    assign wr_ctrl = wr_access && sel_ctrl;

    // single shots end with the conversion; continuous ends only on a stop hit
    assign hw_stop = conv_in.done
        && (!continuous_retrigger || (calc_cfg.stop_on_threshold && thresh_hit));

    always_comb
    begin
        next_go = go;
        if (hw_stop)
        begin
            next_go = 1'b0;
        end
        if (wr_ctrl)
        begin
            next_go = pwdata[`ATC_CTRL_GO];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            go <= 1'b0;
            continuous_retrigger <= 1'b0;
            double_sample_enable <= 1'b0;
            previous_source_select <= 1'b0;
        end
        else
        begin
            go <= next_go;
            if (wr_ctrl)
            begin
                continuous_retrigger <= pwdata[`ATC_CTRL_CONTINUOUS_RETRIGGER];
                double_sample_enable <= pwdata[`ATC_CTRL_DOUBLE_SAMPLE_ENABLE];
                previous_source_select <= pwdata[`ATC_CTRL_PREVIOUS_SOURCE_SELECT];
            end
        end
    end

    // ----------------------------------------------------------------
    // computation control and limits
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            calc_cfg <= '0;
        end
        else if (wr_access && sel_calc)
        begin
            calc_cfg.error_calc_mode <= pwdata[`ATC_CALC_HI:`ATC_CALC_LO];
            calc_cfg.stop_on_threshold <= pwdata[`ATC_CALC_SOI];
            calc_cfg.threshold_irq_mode <= pwdata[`ATC_TMD_HI:`ATC_TMD_LO];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            setpoint_value <= `ATC_THR_RST;
            lower_threshold <= `ATC_THR_RST;
            upper_threshold <= `ATC_THR_RST;
        end
        else
        begin
            if (wr_access && sel_setpoint_value)
            begin
                setpoint_value <= pwdata[`ATC_THR_W-1:0];
            end
            if (wr_access && sel_lth)
            begin
                lower_threshold <= pwdata[`ATC_THR_W-1:0];
            end
            if (wr_access && sel_uth)
            begin
                upper_threshold <= pwdata[`ATC_THR_W-1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // result, history and error capture
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            conversion_result <= `ATC_RES_RST;
            prev_result <= `ATC_RES_RST;
            prev_filtered <= `ATC_THR_RST;
            error_value <= `ATC_ERR_RST;
        end
        else if (conv_in.done)
        begin
            conversion_result <= conv_in.result;
            prev_result <= conv_in.result;
            prev_filtered <= conv_in.filtered_value;
            error_value <= next_error;
        end
        else
        begin
            // software may overwrite the result bytes between conversions
            if (wr_access && sel_resh)
            begin
                conversion_result[11:4] <= pwdata[7:0];
            end
            if (wr_access && sel_resl)
            begin
                conversion_result[3:0] <= pwdata[`ATC_RESL_HI:`ATC_RESL_LO];
            end
        end
    end

    // ----------------------------------------------------------------
    // sticky threshold flag, write one to clear, a new hit wins
    // ----------------------------------------------------------------
    wire logic flag_clr;

    assign flag_clr = wr_access && sel_stat && pwdata[`ATC_STAT_FLAG];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flag <= 1'b0;
        end
        else if (event_hit)
        begin
            flag <= 1'b1;
        end
        else if (flag_clr)
        begin
            flag <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // read data, captured in the setup phase
    // ----------------------------------------------------------------
    logic [31:0] next_rdata;

    always_comb
    begin
        next_rdata = 32'h0000_0000;
        if (sel_ctrl)
        begin
            next_rdata[`ATC_CTRL_GO] = go;
            next_rdata[`ATC_CTRL_CONTINUOUS_RETRIGGER] = continuous_retrigger;
            next_rdata[`ATC_CTRL_DOUBLE_SAMPLE_ENABLE] = double_sample_enable;
            next_rdata[`ATC_CTRL_PREVIOUS_SOURCE_SELECT] = previous_source_select;
        end
        if (sel_calc)
        begin
            next_rdata[`ATC_CALC_HI:`ATC_CALC_LO] = calc_cfg.error_calc_mode;
            next_rdata[`ATC_CALC_SOI] = calc_cfg.stop_on_threshold;
            next_rdata[`ATC_TMD_HI:`ATC_TMD_LO] = calc_cfg.threshold_irq_mode;
        end
        if (sel_resh)
        begin
            next_rdata[7:0] = conversion_result[11:4];
        end
        if (sel_resl)
        begin
            next_rdata[7:0] = {conversion_result[3:0], `ATC_BYTE_ZERO};
        end
        if (sel_setpoint_value)
        begin
            next_rdata[`ATC_THR_W-1:0] = setpoint_value;
        end
        if (sel_lth)
        begin
            next_rdata[`ATC_THR_W-1:0] = lower_threshold;
        end
        if (sel_uth)
        begin
            next_rdata[`ATC_THR_W-1:0] = upper_threshold;
        end
        if (sel_err)
        begin
            next_rdata[`ATC_ERR_W-1:0] = error_value;
        end
        if (sel_stat)
        begin
            next_rdata[`ATC_STAT_FLAG] = flag;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
        end
        else if (setup_phase)
        begin
            prdata <= next_rdata;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign conv_start = go;
    assign threshold_flag = flag;

endmodule : atc_compute
`default_nettype wire

// ---- verilog/atc_defines.svh ----
// What this block does
// - calculation mode is control bits 6-4; a separate bit selects double-sample.
// - mode 000 gives result minus previous; in double-sample this is the measurement.
// - 001 result minus setpoint, 010 result minus filtered; double-sample uses difference.
// - 100 previous minus filtered, 101 filtered minus setpoint; 011/110/111 unused.
// - continuous with stop set clears start once threshold test holds, else retriggers.
// - in continuous with stop clear hardware never clears start; software must clear it.
// - threshold mode 111 always interrupts, mode 000 never does.
// - mode 100 interrupts when error lies below lower or above upper threshold.
// - mode 011 interrupts when error strictly between lower and upper thresholds.
// - mode 110 interrupts above upper; mode 101 at or below upper.
// - mode 001 interrupts below lower; mode 010 at or above lower.
// - in double-sample, previous source select 0 makes the difference second sample minus first.
// - high result byte holds result bits 11 to 4.
// - low result byte holds result bits 3-0 in 7-4; bits 3-0 read zero.
`ifndef ATC_DEFINES_SVH
`define ATC_DEFINES_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define ATC_OFF_CTRL 8'h00
`define ATC_OFF_CALC 8'h04
`define ATC_OFF_RESH 8'h08
`define ATC_OFF_RESL 8'h0c
`define ATC_OFF_SETPOINT_VALUE 8'h10
`define ATC_OFF_LTH 8'h14
`define ATC_OFF_UTH 8'h18
`define ATC_OFF_ERR 8'h1c
`define ATC_OFF_STAT 8'h20

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ATC_CTRL_GO 0
`define ATC_CTRL_CONTINUOUS_RETRIGGER 1
`define ATC_CTRL_DOUBLE_SAMPLE_ENABLE 2
`define ATC_CTRL_PREVIOUS_SOURCE_SELECT 3
`define ATC_CALC_HI 6
`define ATC_CALC_LO 4
`define ATC_CALC_SOI 3
`define ATC_TMD_HI 2
`define ATC_TMD_LO 0
`define ATC_STAT_FLAG 0
`define ATC_RESL_HI 7
`define ATC_RESL_LO 4

// ----------------------------------------------------------------
// widths and reset values
// ----------------------------------------------------------------
`define ATC_ERR_W 18
`define ATC_THR_W 16
`define ATC_RES_RST 12'h000
`define ATC_THR_RST 16'h0000
`define ATC_ERR_RST 18'h00000
`define ATC_BYTE_ZERO 4'h0

`endif

// ---- verilog/atc_pkg.sv ----
`default_nettype none
package atc_pkg;

    typedef enum logic [2:0]
    {
        ATC_CALC_RES_PREV = 3'h0,
        ATC_CALC_RES_SETPOINT_VALUE = 3'h1,
        ATC_CALC_RES_FILTERED_VALUE = 3'h2,
        ATC_CALC_PREV_FILTERED_VALUE = 3'h4,
        ATC_CALC_FILTERED_VALUE_SETPOINT_VALUE = 3'h5
    } atc_calc_e;

    typedef enum logic [2:0]
    {
        ATC_TMD_NEVER = 3'h0,
        ATC_TMD_BELOW_LO = 3'h1,
        ATC_TMD_ATLEAST_LO = 3'h2,
        ATC_TMD_INSIDE = 3'h3,
        ATC_TMD_OUTSIDE = 3'h4,
        ATC_TMD_ATMOST_HI = 3'h5,
        ATC_TMD_ABOVE_HI = 3'h6,
        ATC_TMD_ALWAYS = 3'h7
    } atc_tmd_e;

    // one finished conversion as handed over by the converter
    typedef struct packed
    {
        logic done;
        logic [11:0] result;
        logic [11:0] first_sample;
        logic [15:0] filtered_value;
    } atc_sample_s;

    typedef struct packed
    {
        logic [2:0] error_calc_mode;
        logic stop_on_threshold;
        logic [2:0] threshold_irq_mode;
    } atc_calc_s;

endpackage : atc_pkg
`default_nettype wire

// ---- verilog/atc_thresh_cmp.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "atc_defines.svh"
module atc_thresh_cmp
(
    input wire logic signed [`ATC_ERR_W-1:0] error_value,
    input wire logic signed [`ATC_THR_W-1:0] lower_threshold,
    input wire logic signed [`ATC_THR_W-1:0] upper_threshold,
    input wire logic [2:0] threshold_irq_mode,
    output logic hit
);

    // ----------------------------------------------------------------
    // signed comparisons at the error width
    // ----------------------------------------------------------------
    wire logic signed [`ATC_ERR_W-1:0] lo_ext;
    wire logic signed [`ATC_ERR_W-1:0] hi_ext;
    wire logic below_lo;
    wire logic above_lo;
    wire logic below_hi;
    wire logic above_hi;

    assign lo_ext = `ATC_ERR_W'(lower_threshold);
    assign hi_ext = `ATC_ERR_W'(upper_threshold);
    assign below_lo = error_value < lo_ext;
    assign above_lo = error_value > lo_ext;
    assign below_hi = error_value < hi_ext;
    assign above_hi = error_value > hi_ext;

    always_comb
    begin
        unique case (atc_pkg::atc_tmd_e'(threshold_irq_mode))
            atc_pkg::ATC_TMD_NEVER: hit = 1'b0;
            atc_pkg::ATC_TMD_BELOW_LO: hit = below_lo;
            atc_pkg::ATC_TMD_ATLEAST_LO: hit = !below_lo;
            atc_pkg::ATC_TMD_INSIDE: hit = above_lo && below_hi;
            atc_pkg::ATC_TMD_OUTSIDE: hit = below_lo || above_hi;
            atc_pkg::ATC_TMD_ATMOST_HI: hit = !above_hi;
            atc_pkg::ATC_TMD_ABOVE_HI: hit = above_hi;
            atc_pkg::ATC_TMD_ALWAYS: hit = 1'b1;
        endcase
    end

endmodule : atc_thresh_cmp
`default_nettype wire

// ---- bench/atc_compute_asserts.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "atc_defines.svh"
module atc_compute_asserts
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire atc_pkg::atc_sample_s conv_in,
    input wire logic conv_start,
    input wire logic threshold_flag
);
    logic wr;
    logic ctrl_wr;
    logic continuous_retrigger_q;
    logic soi_q;
    logic [2:0] tmd_q;

    assign wr = psel && penable && pwrite && pready;
    assign ctrl_wr = wr && paddr == `ATC_OFF_CTRL;

    // shadow copies of the control fields the rules depend on
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            continuous_retrigger_q <= 1'b0;
        else if (ctrl_wr)
            continuous_retrigger_q <= pwdata[`ATC_CTRL_CONTINUOUS_RETRIGGER];

    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            {soi_q, tmd_q} <= 4'h0;
        else if (wr && paddr == `ATC_OFF_CALC)
            {soi_q, tmd_q} <= pwdata[3:0];

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence stop_req;
        conv_in.done && conv_start && continuous_retrigger_q && soi_q && !ctrl_wr;
    endsequence

    AST_STOP_ON_HIT: assert property (stop_req ##0 tmd_q == 3'h7 |=> !conv_start)
        else $error("start kept after threshold hit");
    AST_RETRIGGER: assert property (stop_req ##0 tmd_q == 3'h0 |=> conv_start)
        else $error("start cleared without hit");
    AST_NO_HW_CLEAR: assert property (conv_start && continuous_retrigger_q && !soi_q && !ctrl_wr |=> conv_start)
        else $error("start cleared by hardware");
    AST_ALWAYS_IRQ: assert property (conv_in.done && tmd_q == 3'h7 |=> threshold_flag)
        else $error("flag missing in always mode");
    AST_NEVER_IRQ: assert property (!threshold_flag && tmd_q == 3'h0 |=> !threshold_flag)
        else $error("flag set in never mode");
    AST_FLAG_ON_DONE: assert property (!threshold_flag && !conv_in.done |=> !threshold_flag)
        else $error("flag set without conversion");
    AST_FLAG_CLEAR: assert property (wr && paddr == `ATC_OFF_STAT && pwdata[0] && !conv_in.done |=> !threshold_flag)
        else $error("flag not cleared");
    AST_LOW_BITS_ZERO: assert property (psel && penable && !pwrite && paddr == `ATC_OFF_RESL |-> prdata[3:0] == 4'h0)
        else $error("low result bits not zero");
endmodule : atc_compute_asserts

bind atc_compute atc_compute_asserts u_chk (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .conv_in(conv_in), .conv_start(conv_start),
    .threshold_flag(threshold_flag));
`default_nettype wire

// ---- bench/adc_threshold_compute_test.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "atc_defines.svh"
module adc_threshold_compute_test;
    logic pclk;
    logic presetn;
    logic [7:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    atc_pkg::atc_sample_s conv_in;
    logic conv_start;
    logic threshold_flag;
    int n_mismatch;
    int cmp_count;
    logic [31:0] rd;
    logic rerr;
    logic [11:0] prev_res;
    logic [15:0] prev_flt;

    atc_compute uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .conv_in(conv_in), .conv_start(conv_start),
        .threshold_flag(threshold_flag));

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // ------------------------------------------------
    // bus and converter drivers
    // ------------------------------------------------
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // idle cycle: outputs launched by the access edge settle before callers look
        @(posedge pclk);
    endtask : apb

    task conv(input logic [11:0] r, input logic [11:0] f, input logic [15:0] v);
        conv_in <= '{1'b1, r, f, v};
        @(posedge pclk);
        conv_in.done <= 1'b0;
        @(posedge pclk);
        prev_res = r;
        prev_flt = v;
    endtask : conv

    function automatic logic [17:0] exp_err(input logic [2:0] m, input logic ds,
        input logic ps, input logic [11:0] r, input logic [11:0] f, input logic [15:0] v,
        input logic [15:0] sp);
        logic [17:0] rr;
        logic [17:0] vv;
        logic [17:0] ss;
        logic [17:0] pv;
        logic [17:0] t;
        logic [17:0] b;
        rr = {6'h0, r};
        vv = {{2{v[15]}}, v};
        ss = {{2{sp[15]}}, sp};
        pv = ps ? {{2{prev_flt[15]}}, prev_flt} : {6'h0, prev_res};
        t = (ds && !ps) ? rr - {6'h0, f} : rr - pv;
        b = ds ? t : rr;
        case (m)
            3'h0: return t;
            3'h1: return b - ss;
            3'h2: return b - vv;
            3'h4: return pv - vv;
            3'h5: return vv - ss;
            default: return 18'h0;
        endcase
    endfunction : exp_err

    // ------------------------------------------------
    // scenarios
    // ------------------------------------------------
    task t_reset();
        for (int a = 0; a <= 32; a += 4)
        begin
            apb(1'b0, a[7:0], 32'h0);
            chk(rd, 32'h0);
            chk({31'h0, rerr}, 32'h0);
        end
        apb(1'b1, 8'h24, 32'hffff_ffff);
        apb(1'b0, 8'h24, 32'h0);
        chk({rd[30:0], rerr}, 32'h1);
    endtask : t_reset

    task t_calc();
        logic [11:0] r;
        logic [15:0] v;
        logic [17:0] e;
        apb(1'b1, `ATC_OFF_SETPOINT_VALUE, 32'h0000_0123);
        for (int i = 0; i < 32; i++)
        begin
            r = 12'(12'h100 + i * 37);
            v = 16'(16'hff80 + i * 3);
            apb(1'b1, `ATC_OFF_CTRL, {28'h0, i[4], i[3], 2'h0});
            apb(1'b1, `ATC_OFF_CALC, {25'h0, i[2:0], 4'h0});
            e = exp_err(i[2:0], i[3], i[4], r, 12'(12'h0f0 + i), v, 16'h0123);
            conv(r, 12'(12'h0f0 + i), v);
            apb(1'b0, `ATC_OFF_ERR, 32'h0);
            chk(rd, {14'h0, e});
        end
    endtask : t_calc

    task t_thr();
        int ev [5] = '{-11, -10, 0, 20, 21};
        int e;
        logic h;
        apb(1'b1, `ATC_OFF_CTRL, 32'h0);
        apb(1'b1, `ATC_OFF_SETPOINT_VALUE, 32'h0000_0100);
        apb(1'b1, `ATC_OFF_LTH, 32'h0000_fff6);
        apb(1'b1, `ATC_OFF_UTH, 32'h0000_0014);
        for (int i = 0; i < 40; i++)
        begin
            e = ev[i % 5];
            case (i / 5)
                0: h = 1'b0;
                1: h = e < -10;
                2: h = e >= -10;
                3: h = e > -10 && e < 20;
                4: h = e < -10 || e > 20;
                5: h = e <= 20;
                6: h = e > 20;
                default: h = 1'b1;
            endcase
            apb(1'b1, `ATC_OFF_CALC, {25'h0, 3'h1, 1'b0, 3'(i / 5)});
            apb(1'b1, `ATC_OFF_STAT, 32'h1);
            conv(12'(256 + e), 12'h0, 16'h0);
            chk({31'h0, threshold_flag}, {31'h0, h});
            apb(1'b0, `ATC_OFF_STAT, 32'h0);
            chk(rd, {31'h0, h});
        end
    endtask : t_thr

    task t_stop();
        apb(1'b1, `ATC_OFF_CTRL, 32'h3);
        apb(1'b1, `ATC_OFF_CALC, 32'h18);
        conv(12'h010, 12'h0, 16'h0);
        chk({31'h0, conv_start}, 32'h1);
        apb(1'b1, `ATC_OFF_CALC, 32'h1f);
        conv(12'h020, 12'h0, 16'h0);
        chk({31'h0, conv_start}, 32'h0);
        apb(1'b1, `ATC_OFF_CTRL, 32'h3);
        apb(1'b1, `ATC_OFF_CALC, 32'h17);
        conv(12'h030, 12'h0, 16'h0);
        conv(12'h040, 12'h0, 16'h0);
        chk({31'h0, conv_start}, 32'h1);
        apb(1'b1, `ATC_OFF_CTRL, 32'h2);
        chk({31'h0, conv_start}, 32'h0);
        apb(1'b1, `ATC_OFF_CTRL, 32'h1);
        conv(12'h050, 12'h0, 16'h0);
        chk({31'h0, conv_start}, 32'h0);
    endtask : t_stop

    task t_res();
        conv(12'hab5, 12'h0, 16'h0);
        apb(1'b0, `ATC_OFF_RESH, 32'h0);
        chk(rd, 32'hab);
        apb(1'b0, `ATC_OFF_RESL, 32'h0);
        chk(rd, 32'h50);
        apb(1'b1, `ATC_OFF_RESL, 32'hff);
        apb(1'b0, `ATC_OFF_RESL, 32'h0);
        chk(rd, 32'hf0);
        apb(1'b1, `ATC_OFF_RESH, 32'h3c);
        apb(1'b0, `ATC_OFF_RESH, 32'h0);
        chk(rd, 32'h3c);
    endtask : t_res

    task test_done();
        $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        conv_in = '0;
        n_mismatch = 0;
        cmp_count = 0;
        prev_res = 12'h0;
        prev_flt = 16'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_calc();
        t_thr();
        t_stop();
        t_res();
        test_done();
    end

    initial
    begin
        #100000;
        n_mismatch++;
        test_done();
    end
endmodule : adc_threshold_compute_test
`default_nettype wire
